/* File: src/pot_pkg.sv */
// Package: constants, codes and carrier types for the serial potentiometer command logic.
// Assumes a single 10 MHz system clock.
package pot_pkg;
	localparam int CLK_HZ = 10000000;
	localparam int WRITE_TYPICAL_MS = 5;
	localparam int WRITE_MAX_MS = 10;
	localparam int WRITE_CYCLES = WRITE_TYPICAL_MS * (CLK_HZ / 1000);
	localparam int WRITE_LIMIT_CYCLES = WRITE_MAX_MS * (CLK_HZ / 1000);
	localparam int WIPER_RESPONSE_NS = 100;
	localparam int WIPER_RESPONSE_CYCLES = (WIPER_RESPONSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam logic [3:0] DEVICE_TYPE_ID = 4'hA; // Arbitrary value
	localparam logic [3:0] OP_READ_WIPER = 4'h9;
	localparam logic [3:0] OP_WRITE_WIPER = 4'hA;
	localparam logic [3:0] OP_READ_STORED = 4'hB;
	localparam logic [3:0] OP_WRITE_STORED = 4'hC;
	localparam logic [3:0] OP_COPY_TO_WIPER = 4'hD;
	localparam logic [3:0] OP_COPY_TO_STORED = 4'hE;
	localparam logic [3:0] OP_STEP = 4'h2;
	localparam int OPCODE_MSB = 7;
	localparam int SELECT_MSB = 3;
	localparam int WIPER_WIDTH = 6;
	localparam logic [5:0] WIPER_MAX = 6'h3F;
	localparam logic [5:0] WIPER_RESET = 6'h00;

	typedef struct packed {
		logic [3:0] opcode;
		logic [1:0] select;
		logic [1:0] pad;
	} instruction_type;

	typedef struct packed {
		logic start;
		logic stop;
		logic rise;
		logic fall;
		logic sda;
	} bus_event_type;
endpackage : pot_pkg

/* File: src/stored_setting_memory.sv */
// Holds the four stored-setting registers with a registered read port.
// Assumes the caller sequences writes with its own write timer.
`timescale 1ns/1ps
`default_nettype none
module stored_setting_memory #(
	parameter int WIDTH = 6,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic write_en,
	input wire logic [$clog2(DEPTH)-1:0] write_addr,
	input wire logic [WIDTH-1:0] write_data,
	input wire logic [$clog2(DEPTH)-1:0] read_addr,
	output logic [WIDTH-1:0] read_data
);
	// Cleared contents give the power-up load a defined value
	logic [WIDTH-1:0] mem [DEPTH] = '{default: '0};

	always_ff @(posedge clk) begin
		if (write_en) begin
			mem[write_addr] <= write_data;
		end
	end

	always_ff @(posedge clk) begin
		read_data <= mem[read_addr];
	end
endmodule : stored_setting_memory
`default_nettype wire

/* File: src/serial_pot_command_logic.sv */
// Two-wire slave command logic: address match, instruction decode, wiper register and stored settings.
// Assumes SCL and SDA arrive asynchronously; SDA is open drain, driven low only while SDA_OE is high.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Acknowledge only when address bits 3, 2 and 0 match the three straps and bit 1 is zero.
// - Stop after a nonvolatile write starts the write cycle; inputs are ignored.
// - Withhold address acknowledge while writing; acknowledge once finished.
// - Instruction byte: opcode upper four, select next two, lowest two zero.
// - Opcode 1001 reads, 1010 writes the wiper position register.
// - Opcode 1011 reads, 1100 writes the selected stored setting.
// - 1101 copies stored setting to wiper; 1110 copies wiper to stored setting.
// - Opcode 0010 with select zero enables wiper stepping; the logic accepts opcode 0010 with any select.
// - Copy commands end after instruction; reads and writes carry a data byte.
// - Copy to wiper is volatile; wiper output follows after response delay.
// - Copy wiper to stored setting runs as a nonvolatile write.
// - While stepping, a clock high with data high steps up.
// - While stepping, a clock high with data low steps down.
// - Wiper is a 6-bit counter decoded to one of sixty-four switches.
// - At power-up the wiper loads from stored setting zero.
// - Every stored-setting change is a nonvolatile write finishing within 10 ms.
// - Upper four address bits must match the fixed device type identifier.
// - Acknowledge address, instruction, and a following data byte.
// - Write-protect low blocks all nonvolatile writes.
module serial_pot_command_logic #(
	parameter int WRITE_CYCLES = pot_pkg::WRITE_CYCLES,
	parameter logic [3:0] DEVICE_TYPE = pot_pkg::DEVICE_TYPE_ID
) (
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic SCL,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input wire logic ADDRESS_STRAP_LOW,
	input wire logic ADDRESS_STRAP_MID,
	input wire logic ADDRESS_STRAP_HIGH,
	input wire logic WRITE_PROTECT_N,
	output logic [5:0] WIPER_POSITION,
	output logic [63:0] WIPER_SWITCH,
	output logic WRITE_BUSY
);
	typedef enum {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_INSTR, ST_INSTR_ACK, ST_WDATA, ST_WDATA_ACK,
		ST_RDATA, ST_RDATA_ACK, ST_STEP, ST_IGNORE
	} state_type;

	state_type state;
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic [1:0] wp_sync;
	logic [2:0] strap_sync0;
	logic [2:0] strap_sync1;
	logic scl_prev;
	logic sda_prev;
	pot_pkg::bus_event_type ev;
	logic [2:0] bit_count;
	logic [7:0] shift;
	pot_pkg::instruction_type instr;
	logic [5:0] wiper;
	logic [5:0] wiper_shown;
	logic [$clog2(pot_pkg::WIPER_RESPONSE_CYCLES+1)-1:0] response_count;
	logic response_pending;
	logic pending_write;
	logic [1:0] pending_addr;
	logic [5:0] pending_data;
	logic [31:0] write_count;
	logic mem_write_en;
	logic [1:0] mem_read_addr;
	logic [5:0] mem_read_data;
	logic powerup_load;
	logic [1:0] powerup_phase;
	logic [7:0] read_shift;
	logic addr_match;
	logic ack_drive;

	function automatic logic [5:0] step_wiper(input logic [5:0] value, input logic up);
		if (up) begin
			step_wiper = (value == pot_pkg::WIPER_MAX) ? value : 6'(value + 6'h01);
		end else begin
			step_wiper = (value == 6'h00) ? value : 6'(value - 6'h01);
		end
	endfunction : step_wiper

	function automatic logic [63:0] one_hot(input logic [5:0] value);
		one_hot = 64'h1 << value;
	endfunction : one_hot

	stored_setting_memory #(
		.WIDTH(pot_pkg::WIPER_WIDTH),
		.DEPTH(4)
	) stored_setting_memory_inst (
		.clk(REF_CLK),
		.write_en(mem_write_en),
		.write_addr(pending_addr),
		.write_data(pending_data),
		.read_addr(mem_read_addr),
		.read_data(mem_read_data)
	);

	// Input synchronisers
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			wp_sync <= 2'h0;
			strap_sync0 <= 3'h0;
			strap_sync1 <= 3'h0;
		end else begin
			scl_sync <= {scl_sync[0], SCL};
			sda_sync <= {sda_sync[0], SDA_IN};
			wp_sync <= {wp_sync[0], WRITE_PROTECT_N};
			strap_sync0 <= {ADDRESS_STRAP_HIGH, ADDRESS_STRAP_MID, ADDRESS_STRAP_LOW};
			strap_sync1 <= strap_sync0;
		end
	end

	// Bus condition detection
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_prev <= scl_sync[1];
			sda_prev <= sda_sync[1];
		end
	end

	always_comb begin
		ev.sda = sda_sync[1];
		ev.start = scl_sync[1] && scl_prev && sda_prev && !sda_sync[1];
		ev.stop = scl_sync[1] && scl_prev && !sda_prev && sda_sync[1];
		ev.rise = scl_sync[1] && !scl_prev;
		ev.fall = !scl_sync[1] && scl_prev;
	end

	// Address byte: type id, then strap high, strap mid, unstrapped zero, strap low
	always_comb begin
		addr_match = (shift[7:4] == DEVICE_TYPE)
			&& (shift[3:0] == {strap_sync1[2], strap_sync1[1], 1'b0, strap_sync1[0]});
	end

	assign mem_read_addr = powerup_load ? 2'h0 : instr.select;

	// Command state machine
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			state <= ST_IDLE;
			bit_count <= 3'h0;
			shift <= 8'h00;
			instr <= '0;
			ack_drive <= 1'b0;
			read_shift <= 8'h00;
		end else if (ev.start) begin
			state <= ST_ADDR;
			bit_count <= 3'h0;
			shift <= 8'h00;
			ack_drive <= 1'b0;
		end else if (ev.stop) begin
			state <= ST_IDLE;
			ack_drive <= 1'b0;
		end else begin
			case (state)
				ST_IDLE, ST_IGNORE: begin
					ack_drive <= 1'b0;
				end
				ST_ADDR, ST_INSTR, ST_WDATA: begin
					if (ev.rise) begin
						shift <= {shift[6:0], ev.sda};
						bit_count <= 3'(bit_count + 3'h1);
					end else if (ev.fall && bit_count == 3'h0 && shift != 8'h00 && state == ST_ADDR) begin
						if (addr_match && !WRITE_BUSY && !pending_write && !powerup_load) begin
							ack_drive <= 1'b1;
							state <= ST_ADDR_ACK;
						end else begin
							state <= ST_IGNORE;
						end
					end
					if (ev.fall && bit_count == 3'h0 && state == ST_INSTR) begin
						instr <= shift;
						case (shift[7:4])
							pot_pkg::OP_READ_WIPER, pot_pkg::OP_WRITE_WIPER, pot_pkg::OP_READ_STORED,
							pot_pkg::OP_WRITE_STORED, pot_pkg::OP_COPY_TO_WIPER, pot_pkg::OP_COPY_TO_STORED,
							pot_pkg::OP_STEP: begin
								ack_drive <= 1'b1;
								state <= ST_INSTR_ACK;
							end
							default: state <= ST_IGNORE;
						endcase
					end
					if (ev.fall && bit_count == 3'h0 && state == ST_WDATA) begin
						ack_drive <= 1'b1;
						state <= ST_WDATA_ACK;
					end
				end
				ST_ADDR_ACK: begin
					if (ev.fall) begin
						ack_drive <= 1'b0;
						shift <= 8'h00;
						state <= ST_INSTR;
					end
				end
				ST_INSTR_ACK: begin
					if (ev.fall) begin
						ack_drive <= 1'b0;
						case (instr.opcode)
							pot_pkg::OP_READ_WIPER: begin
								read_shift <= {2'b00, wiper};
								state <= ST_RDATA;
							end
							pot_pkg::OP_READ_STORED: begin
								read_shift <= {2'b00, mem_read_data};
								state <= ST_RDATA;
							end
							pot_pkg::OP_WRITE_WIPER, pot_pkg::OP_WRITE_STORED: state <= ST_WDATA;
							pot_pkg::OP_STEP: state <= ST_STEP;
							default: state <= ST_IGNORE;
						endcase
					end
				end
				ST_WDATA_ACK: begin
					if (ev.fall) begin
						ack_drive <= 1'b0;
						state <= ST_IGNORE;
					end
				end
				ST_RDATA: begin
					if (ev.fall) begin
						read_shift <= {read_shift[6:0], 1'b1};
						bit_count <= 3'(bit_count + 3'h1);
						if (bit_count == 3'h7) begin
							state <= ST_RDATA_ACK;
						end
					end
				end
				ST_RDATA_ACK: begin
					if (ev.fall) begin
						state <= ST_IGNORE;
					end
				end
				ST_STEP: begin
					ack_drive <= 1'b0;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Open-drain data drive
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			SDA_OE <= 1'b0;
			SDA_OUT <= 1'b0;
		end else begin
			SDA_OUT <= 1'b0;
			SDA_OE <= ack_drive || (state == ST_RDATA && !read_shift[7]);
		end
	end

	// Wiper position register
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			wiper <= pot_pkg::WIPER_RESET;
			powerup_load <= 1'b1;
			powerup_phase <= 2'h0;
		end else if (powerup_load) begin
			powerup_phase <= 2'(powerup_phase + 2'h1);
			if (powerup_phase == 2'h2) begin
				wiper <= mem_read_data;
				powerup_load <= 1'b0;
			end
		end else if (state == ST_WDATA && ev.fall && bit_count == 3'h0
				&& instr.opcode == pot_pkg::OP_WRITE_WIPER) begin
			wiper <= shift[5:0];
		end else if (state == ST_INSTR_ACK && ev.fall && instr.opcode == pot_pkg::OP_COPY_TO_WIPER) begin
			wiper <= mem_read_data;
		end else if (state == ST_STEP && ev.fall) begin
			wiper <= step_wiper(wiper, sda_prev);
		end
	end

	// Wiper output follows after the response delay
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			wiper_shown <= pot_pkg::WIPER_RESET;
			response_count <= '0;
			response_pending <= 1'b0;
			WIPER_POSITION <= pot_pkg::WIPER_RESET;
			WIPER_SWITCH <= 64'h1;
		end else begin
			if (wiper != wiper_shown) begin
				wiper_shown <= wiper;
				response_pending <= 1'b1;
				response_count <= '0;
			end else if (response_pending) begin
				response_count <= response_count + 1'b1;
				if (response_count == ($bits(response_count))'(pot_pkg::WIPER_RESPONSE_CYCLES - 1)) begin
					response_pending <= 1'b0;
					WIPER_POSITION <= wiper_shown;
					WIPER_SWITCH <= one_hot(wiper_shown);
				end
			end
		end
	end

	// Nonvolatile write capture and timer
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			pending_write <= 1'b0;
			pending_addr <= 2'h0;
			pending_data <= 6'h00;
			write_count <= 32'h0;
			WRITE_BUSY <= 1'b0;
			mem_write_en <= 1'b0;
		end else begin
			mem_write_en <= 1'b0;
			if (state == ST_WDATA && ev.fall && bit_count == 3'h0
					&& instr.opcode == pot_pkg::OP_WRITE_STORED && wp_sync[1]) begin
				pending_write <= 1'b1;
				pending_addr <= instr.select;
				pending_data <= shift[5:0];
			end else if (state == ST_INSTR_ACK && ev.fall
					&& instr.opcode == pot_pkg::OP_COPY_TO_STORED && wp_sync[1]) begin
				pending_write <= 1'b1;
				pending_addr <= instr.select;
				pending_data <= wiper;
			end else if (pending_write && ev.start) begin
				pending_write <= 1'b0;
			end else if (pending_write && ev.stop && !WRITE_BUSY) begin
				pending_write <= 1'b0;
				WRITE_BUSY <= 1'b1;
				write_count <= 32'h0;
			end
			if (WRITE_BUSY) begin
				write_count <= write_count + 32'h1;
				if (write_count == 32'(WRITE_CYCLES - 1)) begin
					WRITE_BUSY <= 1'b0;
					mem_write_en <= 1'b1;
				end
			end
		end
	end
endmodule : serial_pot_command_logic
`default_nettype wire

/* File: dv/serial_pot_asserts.sv */
// Checker: port-level timing of acknowledge, write cycle and wiper decode.
// Assumes each SCL phase lasts at least five REF_CLK cycles.
`timescale 1ns/1ps
`default_nettype none
module serial_pot_asserts #(
	parameter int WRITE_CYCLES = 300
) (
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic SCL,
	input wire logic SDA_IN,
	input wire logic SDA_OUT,
	input wire logic SDA_OE,
	input wire logic [5:0] WIPER_POSITION,
	input wire logic [63:0] WIPER_SWITCH,
	input wire logic WRITE_BUSY
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);
	logic [15:0] busy_cnt;
	logic [7:0] since_stop;
	// Busy length and distance from the last stop
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST || !WRITE_BUSY) busy_cnt <= 16'h0000;
		else busy_cnt <= busy_cnt + 16'h0001;
	end
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) since_stop <= 8'hFF;
		else if (SCL && $rose(SDA_IN)) since_stop <= 8'h00;
		else if (since_stop != 8'hFF) since_stop <= since_stop + 8'h01;
	end
	sequence s_settled;
		$stable(WIPER_POSITION) [*3];
	endsequence
	AST_ONE_SWITCH: assert property ($onehot(WIPER_SWITCH)) else $error("switch not one-hot");
	AST_DECODE: assert property (s_settled |-> WIPER_SWITCH == (64'h1 << WIPER_POSITION))
		else $error("switch does not match wiper");
	AST_NO_ACK_BUSY: assert property (WRITE_BUSY |-> !SDA_OE) else $error("ack while writing");
	AST_WRITE_START: assert property ($rose(WRITE_BUSY) |-> since_stop <= 8) else $error("write without stop");
	AST_WRITE_LEN: assert property ($fell(WRITE_BUSY) |-> busy_cnt >= WRITE_CYCLES - 3 &&
		busy_cnt <= WRITE_CYCLES + 3) else $error("write cycle length wrong");
	AST_FROZEN: assert property (WRITE_BUSY && $past(WRITE_BUSY) |-> $stable(WIPER_POSITION))
		else $error("wiper moved while writing");
	AST_ACK_LOW: assert property ($rose(SDA_OE) |-> !SCL && !$past(SCL)) else $error("ack raised in high");
	AST_SDA_HOLD: assert property (SCL && $past(SCL) |-> $stable(SDA_OE)) else $error("SDA moved in high");
	AST_OPEN_DRAIN: assert property (SDA_OUT == 1'b0) else $error("SDA driven high");
endmodule : serial_pot_asserts
bind serial_pot_command_logic serial_pot_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) serial_pot_asserts_inst (
	.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
	.WIPER_POSITION(WIPER_POSITION), .WIPER_SWITCH(WIPER_SWITCH), .WRITE_BUSY(WRITE_BUSY));
`default_nettype wire

/* File: dv/bus_master.sv */
// Two-wire bus master model: start, stop, bit and byte transfers.
// Assumes the bench resolves the open-drain SDA wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module bus_master #(
	parameter int P = 6
) (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_drv
);
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic wt();
		repeat (P) @(negedge clk);
	endtask : wt
	// Data changes only while SCL is low
	task automatic bit_x(input logic b, output logic r);
		sda_drv = b;
		wt();
		scl = 1'b1;
		wt();
		r = sda;
		scl = 1'b0;
	endtask : bit_x
	task automatic start();
		sda_drv = 1'b1;
		wt();
		scl = 1'b1;
		wt();
		sda_drv = 1'b0;
		wt();
		scl = 1'b0;
	endtask : start
	task automatic stop();
		sda_drv = 1'b0;
		wt();
		scl = 1'b1;
		wt();
		sda_drv = 1'b1;
		wt();
	endtask : stop
	// Released ninth bit leaves the acknowledge slot to the device
	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(d[i], r);
		bit_x(1'b1, r);
		ack = !r;
	endtask : send
	task automatic recv(output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
		bit_x(1'b1, r);
	endtask : recv
endmodule : bus_master
`default_nettype wire

/* File: dv/serial_pot_command_logic_bench.sv */
// Bench: drives the command logic through the bus master model and checks acks and wiper.
// Assumes a pull-up on SDA and a shortened write cycle.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; $display("unexpected %0t %h %h", $time, a, b); end end
module serial_pot_command_logic_bench;
	localparam int WC = 300;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic s_h = 1'b1;
	logic s_m = 1'b0;
	logic s_l = 1'b1;
	logic wp_n = 1'b1;
	logic scl, drv, oe, busy;
	logic [5:0] wiper;
	logic [63:0] sw;
	logic [7:0] adr;
	wire logic sda;
	int errors = 0;
	int checked = 0;
	assign sda = drv & !oe;
	assign adr = {pot_pkg::DEVICE_TYPE_ID, 4'b1001};
	always #50 clk = ~clk;
	serial_pot_command_logic #(.WRITE_CYCLES(WC)) serial_pot_command_logic_inst (.REF_CLK(clk), .SYS_RST(rst),
		.SCL(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(oe), .ADDRESS_STRAP_LOW(s_l), .ADDRESS_STRAP_MID(s_m),
		.ADDRESS_STRAP_HIGH(s_h), .WRITE_PROTECT_N(wp_n), .WIPER_POSITION(wiper), .WIPER_SWITCH(sw), .WRITE_BUSY(busy));
	bus_master bus_master_inst (.clk(clk), .sda(sda), .scl(scl), .sda_drv(drv));
	task automatic stop_test();
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	task automatic head(input logic [7:0] ins);
		logic a;
		bus_master_inst.start();
		bus_master_inst.send(adr, a);
		`CHK(a, 1'b1)
		bus_master_inst.send(ins, a);
		`CHK(a, 1'b1)
	endtask : head
	task automatic cmd(input logic [7:0] ins, input logic has_d, input logic [7:0] d);
		logic a;
		head(ins);
		if (has_d) begin
			bus_master_inst.send(d, a);
			`CHK(a, 1'b1)
		end
		bus_master_inst.stop();
	endtask : cmd
	task automatic rd(input logic [7:0] ins, input logic [5:0] e);
		logic [7:0] v;
		head(ins);
		bus_master_inst.recv(v);
		bus_master_inst.stop();
		`CHK(v, {2'b00, e})
	endtask : rd
	task automatic poll(output int n);
		logic a;
		for (n = 1; n <= 40; n++) begin
			bus_master_inst.start();
			bus_master_inst.send(adr, a);
			bus_master_inst.stop();
			if (a) return;
		end
		errors++;
		stop_test();
	endtask : poll
	task automatic t_wiper();
		cmd(8'hA0, 1'b1, 8'h2A);
		`CHK(wiper, 6'h2A)
		`CHK(sw, 64'h1 << 42)
		rd(8'h90, 6'h2A);
		$display("wiper done");
	endtask : t_wiper
	task automatic t_addr();
		logic a;
		logic [7:0] bad [4] = '{adr ^ 8'h80, adr ^ 8'h04, adr ^ 8'h10, adr ^ 8'h02};
		for (int i = 0; i < 4; i++) begin
			bus_master_inst.start();
			bus_master_inst.send(bad[i], a);
			bus_master_inst.stop();
			`CHK(a, 1'b0)
		end
		@(negedge clk) s_m = 1'b1;
		bus_master_inst.start();
		bus_master_inst.send(adr, a);
		bus_master_inst.stop();
		`CHK(a, 1'b0)
		@(negedge clk) s_m = 1'b0;
		bus_master_inst.start();
		bus_master_inst.send(adr, a);
		`CHK(a, 1'b1)
		bus_master_inst.send(8'hF0, a);
		bus_master_inst.stop();
		`CHK(a, 1'b0)
		$display("address done");
	endtask : t_addr
	task automatic t_stored();
		int n;
		cmd(8'hC0, 1'b1, 8'h15);
		`CHK(busy, 1'b1)
		poll(n);
		`CHK(n > 1, 1'b1)
		rd(8'hB0, 6'h15);
		`CHK(wiper, 6'h2A)
		$display("stored done");
	endtask : t_stored
	task automatic t_copy();
		int n;
		cmd(8'hE8, 1'b0, 8'h00);
		poll(n);
		rd(8'hB8, 6'h2A);
		cmd(8'hA0, 1'b1, 8'h05);
		cmd(8'hD8, 1'b0, 8'h00);
		`CHK(wiper, 6'h2A)
		cmd(8'hD0, 1'b0, 8'h00);
		`CHK(wiper, 6'h15)
		$display("copy done");
	endtask : t_copy
	task automatic t_step();
		logic r;
		cmd(8'hA0, 1'b1, 8'h01);
		head(8'h20);
		repeat (3) bus_master_inst.bit_x(1'b0, r);
		bus_master_inst.wt();
		`CHK(wiper, 6'h00)
		repeat (2) bus_master_inst.bit_x(1'b1, r);
		bus_master_inst.wt();
		`CHK(wiper, 6'h02)
		bus_master_inst.stop();
		$display("step done");
	endtask : t_step
	task automatic t_protect();
		int n;
		@(negedge clk) wp_n = 1'b0;
		cmd(8'hC4, 1'b1, 8'h33);
		poll(n);
		rd(8'hB4, 6'h00);
		@(negedge clk) wp_n = 1'b1;
		$display("protect done");
	endtask : t_protect
	task automatic t_power();
		@(negedge clk) rst = 1'b1;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		repeat (20) @(negedge clk);
		`CHK(wiper, 6'h15)
		`CHK(sw, 64'h1 << 21)
		$display("power-up done");
	endtask : t_power
	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		repeat (10) @(negedge clk);
		`CHK(wiper, 6'h00)
		t_wiper();
		t_addr();
		t_stored();
		t_copy();
		t_step();
		t_protect();
		t_power();
		stop_test();
	end
endmodule : serial_pot_command_logic_bench
`default_nettype wire
